// file: hdl/sdc_config_regs.sv
// Purpose: decoder and shadow settings bank with the pin functions it steers
// Assumes: single 100 MHz clock; pins reach this block through two flip-flops
// Notes: read data stand one cycle after the read strobe
//
// Contract
// RL1: reg C bit0 set takes off-track from pin one, clear uses internal signal.
// RL2: reg C bits2:1 choose split mute or single mute with pin three fixed.
// RL3: reg D written 0000 gives four-line motor on pins four and five.
// RL4: reg D bits1:0 put subcode, low or high on pin four.
// RL5: reg D bits3:2 put de-emphasis, low or high on pin five.
// RL6: reg E bits3:2 at 01 enable audio features, 00 disable.
// RL7: reg E bit1 set enables lock-to-disc, reset disabled.
// RL8: reg E bit0 clear brakes motor to 12 percent, set to 6.
// RL9: reg F bit2 turns subcode interface on, bit3 picks three-wire format.
// RL10: shadow select set routes later addresses to shadow registers.
// RL11: shadow select clear routes addresses to main decoder registers only.
// RL12: power-on reset loads every field with its initial setting.
// RL13: reg 8 holds loop-filter bandwidth code, reset code 1001.
// RL14: shadow reg 3 bit0 picks slow or mid clock for shared output.
// RL15: shadow reg 3 bit1 set floats the shared clock pin.
// RL16: shadow reg 3 bit2 set floats the fast clock pin.
// RL17: shadow reg 3 bit3 makes dual pin open-drain output three, else input two.
// RL18: a write updates only the addressed nibble, others keep their value.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "sdc_defines.svh"

module sdc_config_regs
    import sdc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // register port
    input wire logic [`SDC_ADDR_W-1:0] addr_i,
    input wire logic [`SDC_DATA_W-1:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    output logic [`SDC_DATA_W-1:0] rdata_o,
    // internal sources steered by the settings
    input wire logic off_track_int_i,
    input wire logic kill_left_i,
    input wire logic kill_right_i,
    input wire logic subcode_q_to_w_i,
    input wire logic deemphasis_i,
    input wire logic motor_line_a_i,
    input wire logic motor_line_b_i,
    input wire logic slow_clock_source_i,
    input wire logic mid_clock_source_i,
    input wire logic fast_clock_source_i,
    // settings to the function blocks
    output logic off_track_o,
    output logic four_line_motor_o,
    output logic deemph_filter_bypass_o,
    output logic audio_features_en_o,
    output logic lock_to_disc_o,
    output logic brake_six_pct_o,
    output logic subcode_if_on_o,
    output logic subcode_three_wire_o,
    output logic shadow_select_bit_o,
    output logic [`SDC_DATA_W-1:0] pll_bw_code_o,
    // versatile pin one (input)
    input wire logic versatile_pin_one_i,
    // dual pin: versatile_input_two / versatile_output_three
    input wire logic dual_pin_i,
    output logic dual_pin_o,
    output logic dual_pin_oe_o,
    output logic versatile_input_two_o,
    // mute pin and versatile pins four and five
    output logic mute_pin_o,
    output logic versatile_pin_four_o,
    output logic versatile_pin_five_o,
    // clock output pins
    output logic shared_clock_out_o,
    output logic shared_clock_out_oe_o,
    output logic fast_clock_out_o,
    output logic fast_clock_out_oe_o
);
    sdc_state_s cur;
    sdc_state_s next_cur;

    sdc_sync_if #(.WIDTH(`SDC_SYNC_W)) pins ();

    sdc_pin_sync #(.WIDTH(`SDC_SYNC_W)) u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .port(pins.sync)
    );

    assign pins.raw[`SDC_SYNC_V1] = versatile_pin_one_i;
    assign pins.raw[`SDC_SYNC_V2] = dual_pin_i;

    logic v1_sync;
    logic v2_sync;
    assign v1_sync = pins.synced[`SDC_SYNC_V1];
    assign v2_sync = pins.synced[`SDC_SYNC_V2];

    // two-bit pin field of pin_interface_b to a mode
    function automatic sdc_pin_mode_e pin_mode(input logic [1:0] f);
        sdc_pin_mode_e m;
        case (f)
            2'h1: m = SDC_PIN_FUNC;
            2'h2: m = SDC_PIN_LOW;
            2'h3: m = SDC_PIN_HIGH;
            default: m = SDC_PIN_SPECIAL;
        endcase
        return m;
    endfunction

    // level of a versatile pin from its mode
    function automatic logic pin_level(input sdc_pin_mode_e m, input logic func,
                                       input logic motor, input logic four_line);
        logic v;
        case (m)
            SDC_PIN_FUNC: v = func;
            SDC_PIN_LOW: v = 1'b0;
            SDC_PIN_HIGH: v = 1'b1;
            // 00 in one field alone is no documented setting; hold the pin high
            SDC_PIN_SPECIAL: v = four_line ? motor : 1'b1;
            default: v = 1'b1;
        endcase
        return v;
    endfunction

    logic shadow_on;
    logic wr_main;
    logic wr_shadow;
    logic four_line;
    sdc_pin_mode_e v4_mode;
    sdc_pin_mode_e v5_mode;
    logic [3:0] reg_addr;

    assign reg_addr = addr_i[3:0];
    assign shadow_on = cur.subcode_shadow_enable[`SDC_F_SHADOW];
    assign wr_main = write_i && !addr_i[4] && !shadow_on; // RL11
    assign wr_shadow = write_i && !addr_i[4] && shadow_on; // RL10
    assign four_line = (cur.pin_interface_b == `SDC_B_FOUR_LINE); // RL3
    assign v4_mode = pin_mode(cur.pin_interface_b[`SDC_B_V4_HI:`SDC_B_V4_LO]);
    assign v5_mode = pin_mode(cur.pin_interface_b[`SDC_B_V5_HI:`SDC_B_V5_LO]);

    always_comb begin
        next_cur = cur;

        // main decoder registers; other addresses belong to blocks outside
        if (wr_main) begin
            case (reg_addr)
                `SDC_ADR_PLL_BW: next_cur.pll_loop_bandwidth = wdata_i; // RL13 RL18
                `SDC_ADR_PIN_A: next_cur.pin_interface_a = wdata_i; // RL18
                `SDC_ADR_PIN_B: next_cur.pin_interface_b = wdata_i; // RL18
                `SDC_ADR_AUDIO: next_cur.audio_motor_features = wdata_i; // RL18
                `SDC_ADR_SUBCODE: next_cur.subcode_shadow_enable = wdata_i; // RL10 RL18
                default: next_cur = cur;
            endcase
        end

        // shadow registers; address F still reaches the enable so software can leave
        if (wr_shadow) begin
            case (reg_addr)
                `SDC_ADR_CLK_PIN: next_cur.clock_pin_control = wdata_i; // RL18
                `SDC_ADR_SUBCODE: next_cur.subcode_shadow_enable = wdata_i; // RL10
                default: next_cur = cur;
            endcase
        end

        // read-back of the currently decoded set
        next_cur.rdata = '0;
        if (read_i) begin
            if (addr_i[4]) begin
                if (reg_addr == `SDC_ADR_STATUS) begin
                    next_cur.rdata[`SDC_ST_V1] = v1_sync; // RL1
                    next_cur.rdata[`SDC_ST_V2] = v2_sync;
                    next_cur.rdata[`SDC_ST_SHADOW] = shadow_on;
                end
            end else if (shadow_on) begin
                case (reg_addr)
                    `SDC_ADR_CLK_PIN: next_cur.rdata = cur.clock_pin_control;
                    `SDC_ADR_SUBCODE: next_cur.rdata = cur.subcode_shadow_enable;
                    default: next_cur.rdata = '0;
                endcase
            end else begin
                case (reg_addr)
                    `SDC_ADR_PLL_BW: next_cur.rdata = cur.pll_loop_bandwidth;
                    `SDC_ADR_PIN_A: next_cur.rdata = cur.pin_interface_a;
                    `SDC_ADR_PIN_B: next_cur.rdata = cur.pin_interface_b;
                    `SDC_ADR_AUDIO: next_cur.rdata = cur.audio_motor_features;
                    `SDC_ADR_SUBCODE: next_cur.rdata = cur.subcode_shadow_enable;
                    default: next_cur.rdata = '0;
                endcase
            end
        end

        // off-track source
        next_cur.off_track = cur.pin_interface_a[`SDC_A_OFFTRACK_EXT] ?
                             v1_sync : off_track_int_i; // RL1

        // mute outputs
        if (!cur.pin_interface_a[`SDC_A_SINGLE_MUTE]) begin
            next_cur.mute_pin = kill_left_i; // RL2
            next_cur.v3_level = kill_right_i; // RL2
        end else begin
            next_cur.mute_pin = kill_left_i | kill_right_i; // RL2
            next_cur.v3_level = cur.pin_interface_a[`SDC_A_V3_LEVEL]; // RL2
        end

        // versatile pins four and five
        next_cur.v4_level = pin_level(v4_mode, subcode_q_to_w_i, motor_line_a_i,
                                      four_line); // RL3 RL4
        next_cur.v5_level = pin_level(v5_mode, deemphasis_i, motor_line_b_i,
                                      four_line); // RL3 RL5

        // clock outputs
        next_cur.shared_clk = cur.clock_pin_control[`SDC_S_MID_SEL] ?
                              mid_clock_source_i : slow_clock_source_i; // RL14
        next_cur.fast_clk = fast_clock_source_i;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cur.pll_loop_bandwidth <= `SDC_RST_PLL_BW; // RL12 RL13
            cur.pin_interface_a <= `SDC_RST_PIN_A; // RL12
            cur.pin_interface_b <= `SDC_RST_PIN_B; // RL12
            cur.audio_motor_features <= `SDC_RST_AUDIO; // RL12
            cur.subcode_shadow_enable <= `SDC_RST_SUBCODE; // RL12
            cur.clock_pin_control <= `SDC_RST_CLK_PIN; // RL12
            cur.rdata <= 4'h0;
            cur.mute_pin <= 1'b0;
            cur.v3_level <= 1'b0;
            cur.v4_level <= 1'b1;
            cur.v5_level <= 1'b1;
            cur.shared_clk <= 1'b0;
            cur.fast_clk <= 1'b0;
            cur.off_track <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // register port
    assign rdata_o = cur.rdata;

    // settings to the function blocks
    assign pll_bw_code_o = cur.pll_loop_bandwidth; // RL13
    assign off_track_o = cur.off_track;
    assign four_line_motor_o = four_line; // RL3
    assign deemph_filter_bypass_o = (v5_mode == SDC_PIN_FUNC); // RL5
    assign audio_features_en_o = (cur.audio_motor_features[`SDC_E_AUDIO_HI:`SDC_E_AUDIO_LO]
                                  == `SDC_E_AUDIO_ON); // RL6
    assign lock_to_disc_o = cur.audio_motor_features[`SDC_E_LOCK]; // RL7
    assign brake_six_pct_o = cur.audio_motor_features[`SDC_E_BRAKE]; // RL8
    assign subcode_if_on_o = cur.subcode_shadow_enable[`SDC_F_SUB_ON]; // RL9
    assign subcode_three_wire_o = cur.subcode_shadow_enable[`SDC_F_THREE_WIRE]; // RL9
    assign shadow_select_bit_o = shadow_on; // RL10

    // dual pin: open-drain output three pulls low only, else input two
    assign dual_pin_o = 1'b0;
    assign dual_pin_oe_o = cur.clock_pin_control[`SDC_S_V3_MODE] && !cur.v3_level; // RL17
    assign versatile_input_two_o = cur.clock_pin_control[`SDC_S_V3_MODE] ?
                                   1'b0 : v2_sync; // RL17

    // pins
    assign mute_pin_o = cur.mute_pin;
    assign versatile_pin_four_o = cur.v4_level;
    assign versatile_pin_five_o = cur.v5_level;
    assign shared_clock_out_o = cur.shared_clk;
    assign shared_clock_out_oe_o = !cur.clock_pin_control[`SDC_S_SHARED_HIZ]; // RL15
    assign fast_clock_out_o = cur.fast_clk;
    assign fast_clock_out_oe_o = !cur.clock_pin_control[`SDC_S_FAST_HIZ]; // RL16
endmodule // sdc_config_regs

// file: hdl/sdc_defines.svh
// Purpose: offsets, field positions and reset values of the servo decoder settings
// Assumes: 4-bit register nibbles, 5-bit local address with bit 4 picking the local page
// Notes: definitions only
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

// widths
`define SDC_ADDR_W 5
`define SDC_DATA_W 4

// main decoder register addresses
`define SDC_ADR_PLL_BW 4'h8
`define SDC_ADR_PIN_A 4'hC
`define SDC_ADR_PIN_B 4'hD
`define SDC_ADR_AUDIO 4'hE
`define SDC_ADR_SUBCODE 4'hF

// shadow register addresses
`define SDC_ADR_CLK_PIN 4'h3

// local page (address bit 4 set)
`define SDC_ADR_STATUS 4'h0

// reset values
`define SDC_RST_PLL_BW 4'h9
`define SDC_RST_PIN_A 4'h2
`define SDC_RST_PIN_B 4'hF
`define SDC_RST_AUDIO 4'h4
`define SDC_RST_SUBCODE 4'h0
`define SDC_RST_CLK_PIN 4'h0

// pin_interface_a fields
`define SDC_A_OFFTRACK_EXT 0
`define SDC_A_SINGLE_MUTE 1
`define SDC_A_V3_LEVEL 2

// pin_interface_b fields
`define SDC_B_V4_LO 0
`define SDC_B_V4_HI 1
`define SDC_B_V5_LO 2
`define SDC_B_V5_HI 3
`define SDC_B_FOUR_LINE 4'h0

// audio_motor_features fields
`define SDC_E_BRAKE 0
`define SDC_E_LOCK 1
`define SDC_E_AUDIO_LO 2
`define SDC_E_AUDIO_HI 3
`define SDC_E_AUDIO_ON 2'h1

// subcode_shadow_enable fields
`define SDC_F_SHADOW 0
`define SDC_F_SUB_ON 2
`define SDC_F_THREE_WIRE 3

// clock_pin_control fields
`define SDC_S_MID_SEL 0
`define SDC_S_SHARED_HIZ 1
`define SDC_S_FAST_HIZ 2
`define SDC_S_V3_MODE 3

// status register fields
`define SDC_ST_V1 0
`define SDC_ST_V2 1
`define SDC_ST_SHADOW 2

// synchronised pin inputs
`define SDC_SYNC_W 2
`define SDC_SYNC_V1 0
`define SDC_SYNC_V2 1

`endif

// file: hdl/sdc_pkg.sv
// Purpose: types shared by the servo decoder settings bank
// Assumes: constants come from sdc_defines.svh
// Notes: one packed struct holds all state of the main module
package sdc_pkg;

    typedef logic [3:0] sdc_nib_t;

    // pin function selected by a two-bit field of pin_interface_b
    typedef enum logic [1:0] {
        SDC_PIN_SPECIAL,
        SDC_PIN_FUNC,
        SDC_PIN_LOW,
        SDC_PIN_HIGH
    } sdc_pin_mode_e;

    typedef struct packed {
        sdc_nib_t pll_loop_bandwidth;
        sdc_nib_t pin_interface_a;
        sdc_nib_t pin_interface_b;
        sdc_nib_t audio_motor_features;
        sdc_nib_t subcode_shadow_enable;
        sdc_nib_t clock_pin_control;
        sdc_nib_t rdata;
        logic mute_pin;
        logic v3_level;
        logic v4_level;
        logic v5_level;
        logic shared_clk;
        logic fast_clk;
        logic off_track;
    } sdc_state_s;

endpackage

// file: hdl/sdc_sync_if.sv
// Purpose: carries raw pin levels to the synchroniser and the settled levels back
// Assumes: one clock domain on the synchronised side
// Notes: none
`timescale 1ns/1ps
interface sdc_sync_if #(parameter int WIDTH = 2);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;

    modport user (output raw, input synced);
    modport sync (input raw, output synced);
endinterface

// file: hdl/sdc_pin_sync.sv
// Purpose: two-flop synchroniser for pin inputs of the settings bank
// Assumes: asynchronous active-low reset
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
module sdc_pin_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // pins in, settled levels out
    sdc_sync_if.sync port
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    stage1[g] <= 1'b0;
                    stage2[g] <= 1'b0;
                end else begin
                    stage1[g] <= port.raw[g];
                    stage2[g] <= stage1[g];
                end
            end
        end
    endgenerate

    assign port.synced = stage2;
endmodule // sdc_pin_sync

// file: bench/sdc_config_regs_asserts.sv
// Purpose: concurrent checks on the ports of the servo decoder settings bank
// Assumes: one clock, asynchronous active-low reset
// Notes: bound from the testbench top file
`timescale 1ns/1ps
`include "sdc_defines.svh"
module sdc_config_regs_asserts (
    // clock, reset and register port
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [`SDC_ADDR_W-1:0] addr_i,
    input wire logic [`SDC_DATA_W-1:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    input wire logic [`SDC_DATA_W-1:0] rdata_o,
    // sources and settings
    input wire logic off_track_int_i,
    input wire logic motor_line_a_i,
    input wire logic deemphasis_i,
    input wire logic off_track_o,
    input wire logic four_line_motor_o,
    input wire logic deemph_filter_bypass_o,
    input wire logic audio_features_en_o,
    input wire logic lock_to_disc_o,
    input wire logic brake_six_pct_o,
    input wire logic subcode_if_on_o,
    input wire logic subcode_three_wire_o,
    input wire logic shadow_select_bit_o,
    input wire logic [`SDC_DATA_W-1:0] pll_bw_code_o,
    input wire logic versatile_pin_four_o,
    input wire logic versatile_pin_five_o,
    input wire logic shared_clock_out_oe_o,
    input wire logic fast_clock_out_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_main_wr(a);
        write_i && !shadow_select_bit_o && addr_i == {1'b0, a};
    endsequence
    sequence s_shadow_wr(a);
        write_i && shadow_select_bit_o && addr_i == {1'b0, a};
    endsequence
    // internal off-track picked, then one more cycle through the output flop
    sequence s_int_track;
        s_main_wr(`SDC_ADR_PIN_A) ##0 !wdata_i[0] ##1 1'b1;
    endsequence

    property p_pll_wr;
        s_main_wr(`SDC_ADR_PLL_BW) |=> pll_bw_code_o == $past(wdata_i);
    endproperty
    a_pll_wr: assert property (p_pll_wr)
        else $error("loop bandwidth write not taken");
    property p_shadow_blk;
        s_shadow_wr(`SDC_ADR_PLL_BW) |=> $stable(pll_bw_code_o);
    endproperty
    a_shadow_blk: assert property (p_shadow_blk)
        else $error("main register changed in shadow mode");
    property p_read;
        read_i && !shadow_select_bit_o && addr_i == {1'b0, `SDC_ADR_PLL_BW}
            |=> rdata_o == $past(pll_bw_code_o);
    endproperty
    a_read: assert property (p_read)
        else $error("read data differ from held code");
    property p_four_line;
        s_main_wr(`SDC_ADR_PIN_B) |=> four_line_motor_o == ($past(wdata_i) == 4'h0);
    endproperty
    a_four_line: assert property (p_four_line)
        else $error("four-line motor decode wrong");
    property p_pin4_motor;
        four_line_motor_o |=> versatile_pin_four_o == $past(motor_line_a_i);
    endproperty
    a_pin4_motor: assert property (p_pin4_motor)
        else $error("pin four not carrying motor line");
    property p_pin5_deemph;
        deemph_filter_bypass_o |=> versatile_pin_five_o == $past(deemphasis_i);
    endproperty
    a_pin5_deemph: assert property (p_pin5_deemph)
        else $error("pin five not carrying de-emphasis");
    property p_offtrack;
        s_int_track |=> off_track_o == $past(off_track_int_i);
    endproperty
    a_offtrack: assert property (p_offtrack)
        else $error("internal off-track not selected");
    property p_audio;
        s_main_wr(`SDC_ADR_AUDIO) |=> audio_features_en_o == ($past(wdata_i[3:2]) == 2'b01)
            && lock_to_disc_o == $past(wdata_i[1]) && brake_six_pct_o == $past(wdata_i[0]);
    endproperty
    a_audio: assert property (p_audio)
        else $error("audio and motor settings wrong");
    property p_subcode;
        write_i && addr_i == {1'b0, `SDC_ADR_SUBCODE} |=> subcode_if_on_o == $past(wdata_i[2])
            && subcode_three_wire_o == $past(wdata_i[3])
            && shadow_select_bit_o == $past(wdata_i[0]);
    endproperty
    a_subcode: assert property (p_subcode)
        else $error("subcode or shadow select wrong");
    property p_clk_oe;
        s_shadow_wr(`SDC_ADR_CLK_PIN) |=> shared_clock_out_oe_o == !$past(wdata_i[1])
            && fast_clock_out_oe_o == !$past(wdata_i[2]);
    endproperty
    a_clk_oe: assert property (p_clk_oe)
        else $error("clock pin enables wrong");
endmodule // sdc_config_regs_asserts

// file: bench/tb_sdc_config_regs.sv
// Purpose: self-checking bench for the servo decoder settings bank
// Assumes: strobes driven just after rising edges, one cycle each
// Notes: ordinary accesses come from a row table
`timescale 1ns/1ps
module tb_sdc_config_regs;
    typedef struct {bit w; logic [4:0] a; logic [3:0] d; logic [3:0] e;} sdc_row_s;
    logic clk_i, resetn_i, write_i, read_i, pin_one, ext_dual, dual_w;
    logic [4:0] addr_i;
    logic [3:0] wdata_i, rdata_o, pll_bw_code_o;
    // 0 off-track, 1/2 kill l/r, 3 subcode, 4 de-emph, 5/6 motor a/b, 7 slow, 8 mid, 9 fast
    logic [9:0] src;
    logic off_track_o, four_line_motor_o, deemph_filter_bypass_o, audio_features_en_o;
    logic lock_to_disc_o, brake_six_pct_o, subcode_if_on_o, subcode_three_wire_o;
    logic shadow_select_bit_o, dual_pin_o, dual_pin_oe_o, versatile_input_two_o, mute_pin_o;
    logic versatile_pin_four_o, versatile_pin_five_o, shared_clock_out_o, shared_clock_out_oe_o;
    logic fast_clock_out_o, fast_clock_out_oe_o;
    int fail_count = 0;
    int checked = 0;
    sdc_row_s rows [12] = '{'{0, 5'h08, 4'h0, 4'h9}, '{0, 5'h0C, 4'h0, 4'h2},
        '{0, 5'h0D, 4'h0, 4'hF}, '{0, 5'h0E, 4'h0, 4'h4}, '{0, 5'h0F, 4'h0, 4'h0},
        '{0, 5'h03, 4'h0, 4'h0}, '{1, 5'h08, 4'h5, 4'h0}, '{0, 5'h08, 4'h0, 4'h5},
        '{1, 5'h09, 4'h7, 4'h0}, '{0, 5'h09, 4'h0, 4'h0}, '{1, 5'h0E, 4'hB, 4'h0},
        '{0, 5'h0E, 4'h0, 4'hB}};

    // open-drain pin with pull-up on the far side
    assign dual_w = dual_pin_oe_o ? dual_pin_o : ext_dual;

    sdc_config_regs sdc_config_regs_inst (.clk_i, .resetn_i, .addr_i, .wdata_i, .write_i,
        .read_i, .rdata_o, .off_track_int_i(src[0]), .kill_left_i(src[1]),
        .kill_right_i(src[2]), .subcode_q_to_w_i(src[3]), .deemphasis_i(src[4]),
        .motor_line_a_i(src[5]), .motor_line_b_i(src[6]), .slow_clock_source_i(src[7]),
        .mid_clock_source_i(src[8]), .fast_clock_source_i(src[9]), .off_track_o,
        .four_line_motor_o, .deemph_filter_bypass_o, .audio_features_en_o, .lock_to_disc_o,
        .brake_six_pct_o, .subcode_if_on_o, .subcode_three_wire_o, .shadow_select_bit_o,
        .pll_bw_code_o, .versatile_pin_one_i(pin_one), .dual_pin_i(dual_w), .dual_pin_o,
        .dual_pin_oe_o, .versatile_input_two_o, .mute_pin_o, .versatile_pin_four_o,
        .versatile_pin_five_o, .shared_clock_out_o, .shared_clock_out_oe_o, .fast_clock_out_o,
        .fast_clock_out_oe_o);

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [3:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        read_i <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [3:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        write_i <= 1'b0;
        read_i <= 1'b1;
        @(posedge clk_i);
        read_i <= 1'b0;
        @(negedge clk_i);
        check(rdata_o, exp);
    endtask

    task automatic settle(input int n);
        @(posedge clk_i);
        write_i <= 1'b0;
        read_i <= 1'b0;
        repeat (n) @(negedge clk_i);
    endtask

    task automatic rst_chk();
        check(pll_bw_code_o, 4'h9);
        check({audio_features_en_o, lock_to_disc_o, brake_six_pct_o, four_line_motor_o},
            4'h8);
        check({versatile_pin_four_o, versatile_pin_five_o, mute_pin_o, dual_pin_oe_o},
            4'hC);
        check({shared_clock_out_oe_o, fast_clock_out_oe_o, subcode_if_on_o,
            shadow_select_bit_o}, 4'hC);
    endtask

    task automatic results();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        resetn_i = 1'b0;
        addr_i = 5'h00;
        wdata_i = 4'h0;
        write_i = 1'b0;
        read_i = 1'b0;
        src = 10'h334;
        pin_one = 1'b1;
        ext_dual = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_chk();
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            else
                rd(rows[i].a, rows[i].e);
        end
        // pin four and five: function, low, high
        for (int f = 1; f < 4; f++) begin
            wr(5'h0D, {f[1:0], f[1:0]});
            settle(2);
            check(versatile_pin_four_o, f == 3);
            check(versatile_pin_five_o, f != 2);
            check(deemph_filter_bypass_o, f == 1);
        end
        wr(5'h0D, 4'h0);
        settle(2);
        check({four_line_motor_o, versatile_pin_four_o, versatile_pin_five_o}, 3'h6);
        // single mute ors both kills, split mute carries the left one
        wr(5'h0C, 4'h2);
        settle(2);
        check(mute_pin_o, 1'b1);
        wr(5'h0C, 4'h0);
        settle(2);
        check(mute_pin_o, 1'b0);
        wr(5'h0C, 4'h3);
        settle(4);
        check(off_track_o, 1'b1);
        check(versatile_input_two_o, 1'b1);
        rd(5'h10, 4'h3);
        wr(5'h0C, 4'h2);
        settle(2);
        check(off_track_o, 1'b0);
        // shadow page: main register locked out, clock pins steered
        wr(5'h0F, 4'hD);
        wr(5'h08, 4'h0);
        wr(5'h03, 4'hB);
        settle(2);
        check(pll_bw_code_o, 4'h5);
        check({shared_clock_out_oe_o, fast_clock_out_oe_o, dual_pin_oe_o}, 3'h3);
        check(shared_clock_out_o, 1'b1);
        check({subcode_three_wire_o, subcode_if_on_o, fast_clock_out_o, dual_pin_o}, 4'hE);
        rd(5'h03, 4'hB);
        rd(5'h10, 4'h5);
        wr(5'h0F, 4'h0);
        wr(5'h03, 4'h0);
        settle(2);
        check({shadow_select_bit_o, shared_clock_out_oe_o}, 2'h0);
        @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        rst_chk();
        results();
    end
endmodule // tb_sdc_config_regs

bind sdc_config_regs sdc_config_regs_asserts sdc_config_regs_asserts_inst (.clk_i, .resetn_i,
    .addr_i, .wdata_i, .write_i, .read_i, .rdata_o, .off_track_int_i, .motor_line_a_i,
    .deemphasis_i, .off_track_o, .four_line_motor_o, .deemph_filter_bypass_o,
    .audio_features_en_o, .lock_to_disc_o, .brake_six_pct_o, .subcode_if_on_o,
    .subcode_three_wire_o, .shadow_select_bit_o, .pll_bw_code_o, .versatile_pin_four_o,
    .versatile_pin_five_o, .shared_clock_out_oe_o, .fast_clock_out_oe_o);
